/* core/mprb_pkg.sv */
// Package: register map, field layout and types for the modem page register bank
package mprb_pkg;
    localparam int          MPRB_ADDR_W        = 7;
    localparam int          MPRB_DATA_W        = 8;
    localparam int          MPRB_FIFO_DEPTH    = 4;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [6:0]  MPRB_ADDR_FIFO     = 7'h00;
    localparam logic [6:0]  MPRB_ADDR_OPMODE   = 7'h01;
    localparam logic [6:0]  MPRB_ADDR_RSVD_A   = 7'h02;
    localparam logic [6:0]  MPRB_ADDR_RSVD_B   = 7'h03;
    localparam logic [6:0]  MPRB_ADDR_RSVD_C   = 7'h04;
    localparam logic [6:0]  MPRB_ADDR_RSVD_D   = 7'h05;
    localparam logic [6:0]  MPRB_ADDR_FRF_HIGH = 7'h06;
    localparam logic [6:0]  MPRB_ADDR_FRF_MID  = 7'h07;
    localparam logic [6:0]  MPRB_ADDR_FRF_LOW  = 7'h08;
    localparam logic [6:0]  MPRB_SHARED_LO     = 7'h0D;
    localparam logic [6:0]  MPRB_SHARED_HI     = 7'h3F;

    // ------------------------------------------------------------
    // Operating-mode field positions and reset values
    // ------------------------------------------------------------
    localparam int          MPRB_BIT_MODEM     = 7;
    localparam int          MPRB_BIT_SHARED    = 6;
    localparam int          MPRB_BIT_BAND      = 3;
    localparam int          MPRB_MODE_MSB      = 2;
    localparam int          MPRB_MODE_LSB      = 0;
    localparam logic        MPRB_RST_MODEM     = 1'h0;
    localparam logic        MPRB_RST_SHARED    = 1'h0;
    localparam logic        MPRB_RST_BAND      = 1'h1;
    localparam logic [7:0]  MPRB_RST_FIFO      = 8'h00;
    localparam logic [7:0]  MPRB_RST_RSVD_C    = 8'h00;
    localparam logic [7:0]  MPRB_RST_FRF_HIGH  = 8'h6C;
    localparam logic [7:0]  MPRB_RST_FRF_MID   = 8'h80;
    localparam logic [7:0]  MPRB_RST_FRF_LOW   = 8'h00;
    localparam logic [7:0]  MPRB_ZERO          = 8'h00;
    localparam int          MPRB_FRF_SHIFT     = 19;

    typedef enum logic [2:0] {
        MPRB_SLEEP      = 3'h0,
        MPRB_STANDBY    = 3'h1,
        MPRB_TX_SYNTH   = 3'h2,
        MPRB_TRANSMIT   = 3'h3,
        MPRB_RX_SYNTH   = 3'h4,
        MPRB_RX_CONT    = 3'h5,
        MPRB_RX_SINGLE  = 3'h6,
        MPRB_MODE_RSVD  = 3'h7
    } mprb_mode_type;

    // Register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } mprb_req_type;

    // Which external page serves an access above the local registers
    typedef enum logic [2:0] {
        MPRB_PAGE_NATIVE = 3'b001,
        MPRB_PAGE_FSK    = 3'b010,
        MPRB_PAGE_SHARED = 3'b100
    } mprb_page_type;
endpackage : mprb_pkg

/* core/mprb_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides and a flush
`timescale 1ns/1ns
`default_nettype none
module mprb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  full,
    output logic                  empty
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wptr;
    logic [PW-1:0]    rptr;
    logic [PW:0]      count;
    logic             do_wr;
    logic             do_rd;

    assign full      = (count == (PW+1)'(DEPTH));
    assign empty     = (count == '0);
    assign in_ready  = !full && !flush;
    assign out_valid = !empty && !flush;
    assign out_data  = mem[rptr];
    assign do_wr     = in_valid && in_ready;
    assign do_rd     = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wptr] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || flush) begin
            wptr  <= '0;
            rptr  <= '0;
            count <= '0;
        end else begin
            if (do_wr) begin
                wptr <= (wptr == PW'(DEPTH-1)) ? '0 : wptr + 1'b1;
            end
            if (do_rd) begin
                rptr <= (rptr == PW'(DEPTH-1)) ? '0 : rptr + 1'b1;
            end
            count <= count + (PW+1)'(do_wr) - (PW+1)'(do_rd);
        end
    end
endmodule : mprb_fifo
`default_nettype wire

/* core/mprb_bank.sv */
// Modem page register bank: FIFO port, operating mode, carrier frequency
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Native page only in spread mode
// - Shared bit maps FSK page 0x0D-0x3F
// - FIFO port; flushed, blocked in sleep
// - Modem bit changes only in sleep
// - Shared bit writable always, acts in spread; reset 0
// - Band set select, resets to one
// - Three-bit device mode, resets to standby
// - Mode write triggers mode action
// - Address 0x06 holds frequency bits 23:16
// - Reserved 0x02/3/5 zero; 0x04 read-write
// - Carrier equals xtal times word over 2^19
module mprb_bank
    import mprb_pkg::*;
#(
    parameter int FIFO_DEPTH = mprb_pkg::MPRB_FIFO_DEPTH
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire mprb_pkg::mprb_req_type req,
    output logic [7:0]                 rdata,
    output logic                       fsk_page_sel,
    output logic                       native_page_sel,
    output logic                       ext_wr,
    output logic                       ext_rd,
    output logic [6:0]                 ext_addr,
    output logic [7:0]                 ext_wdata,
    input  wire logic [7:0]            ext_rdata,
    output logic                       modem_select,
    output logic                       band_set_select,
    output logic [2:0]                 device_mode,
    output logic                       mode_trigger,
    output logic [23:0]                carrier_freq_word,
    output logic                       tx_valid,
    input  wire logic                  tx_ready,
    output logic [7:0]                 tx_data,
    input  wire logic                  rx_valid,
    output logic                       rx_ready,
    input  wire logic [7:0]            rx_data,
    output logic                       fifo_full,
    output logic                       fifo_empty
);
    import mprb_pkg::*;

    // ------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------
    logic          shared_page_select;
    logic [7:0]    reserved_c;
    logic [7:0]    carrier_freq_mid;
    logic [7:0]    carrier_freq_low;
    logic          tx_pop;
    logic          is_sleep;
    logic          in_shared;
    logic          is_local;
    logic          wr_fifo;
    logic          rd_fifo;
    logic          f_in_valid;
    logic [7:0]    f_in_data;
    logic          f_in_ready;
    logic          f_out_valid;
    logic [7:0]    f_out_data;
    logic          f_full;
    logic          f_empty;
    logic [7:0]    next_rdata;
    mprb_page_type page;
    logic          rx_pending;

    assign is_sleep  = (device_mode == MPRB_SLEEP);
    assign in_shared = (req.addr >= MPRB_SHARED_LO) && (req.addr <= MPRB_SHARED_HI);
    assign is_local  = (req.addr <= MPRB_ADDR_FRF_LOW);

    always_comb begin
        if (!modem_select) begin
            page = MPRB_PAGE_FSK;
        end else if (shared_page_select && in_shared) begin
            page = MPRB_PAGE_SHARED;
        end else begin
            page = MPRB_PAGE_NATIVE;
        end
    end

    // ------------------------------------------------------------
    // Operating mode register
    // ------------------------------------------------------------
    // modem bit only in sleep
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            modem_select <= MPRB_RST_MODEM;
        end else if (req.wr && req.addr == MPRB_ADDR_OPMODE && is_sleep) begin
            modem_select <= req.wdata[MPRB_BIT_MODEM];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            shared_page_select <= MPRB_RST_SHARED;
        end else if (req.wr && req.addr == MPRB_ADDR_OPMODE) begin
            shared_page_select <= req.wdata[MPRB_BIT_SHARED];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            band_set_select <= MPRB_RST_BAND;
        end else if (req.wr && req.addr == MPRB_ADDR_OPMODE) begin
            band_set_select <= req.wdata[MPRB_BIT_BAND];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            device_mode <= MPRB_STANDBY;
        end else if (req.wr && req.addr == MPRB_ADDR_OPMODE) begin
            device_mode <= req.wdata[MPRB_MODE_MSB:MPRB_MODE_LSB];
        end
    end

    // trigger pulse on every mode write
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode_trigger <= 1'b0;
        end else begin
            mode_trigger <= req.wr && (req.addr == MPRB_ADDR_OPMODE);
        end
    end

    // Page selects follow the request address as well as the modem and shared bits
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fsk_page_sel    <= !MPRB_RST_MODEM;
            native_page_sel <= MPRB_RST_MODEM;
        end else begin
            fsk_page_sel    <= (page != MPRB_PAGE_NATIVE) && !is_local;
            native_page_sel <= (page == MPRB_PAGE_NATIVE) && !is_local;
        end
    end

    // ------------------------------------------------------------
    // Frequency and reserved registers
    // ------------------------------------------------------------
    // frequency word: high, mid and low bytes
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            carrier_freq_word <= {MPRB_RST_FRF_HIGH, MPRB_RST_FRF_MID, MPRB_RST_FRF_LOW};
        end else if (req.wr && req.addr == MPRB_ADDR_FRF_HIGH) begin
            carrier_freq_word[23:16] <= req.wdata;
        end else if (req.wr && req.addr == MPRB_ADDR_FRF_MID) begin
            carrier_freq_word[15:8] <= req.wdata;
        end else if (req.wr && req.addr == MPRB_ADDR_FRF_LOW) begin
            carrier_freq_word[7:0] <= req.wdata;
        end
    end
    // word feeds synthesiser; f = xtal*word >> MPRB_FRF_SHIFT
    assign carrier_freq_mid = carrier_freq_word[15:8];
    assign carrier_freq_low = carrier_freq_word[7:0];

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reserved_c <= MPRB_RST_RSVD_C;
        end else if (req.wr && req.addr == MPRB_ADDR_RSVD_C) begin
            reserved_c <= req.wdata;
        end
    end

    // ------------------------------------------------------------
    // FIFO data port
    // ------------------------------------------------------------
    // port dead and FIFO flushed in sleep
    assign wr_fifo    = req.wr && req.addr == MPRB_ADDR_FIFO && !is_sleep;
    assign rd_fifo    = req.rd && req.addr == MPRB_ADDR_FIFO && !is_sleep;
    // Modem words count only while the registered ready is shown;
    // limitation: a push beside a software write, or into a just-filled FIFO, is lost
    assign rx_pending = rx_valid && rx_ready && !wr_fifo;
    // Pop only a word the modem side has actually been shown
    assign tx_pop     = tx_valid && tx_ready;
    assign f_in_valid = wr_fifo || rx_pending;
    assign f_in_data  = wr_fifo ? req.wdata : rx_data;

    mprb_fifo #(
        .WIDTH (MPRB_DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (ref_clk),
        .rst       (rst),
        .flush     (is_sleep),
        .in_valid  (f_in_valid),
        .in_ready  (f_in_ready),
        .in_data   (f_in_data),
        .out_valid (f_out_valid),
        .out_ready (rd_fifo || tx_pop),
        .out_data  (f_out_data),
        .full      (f_full),
        .empty     (f_empty)
    );

    // A bubble follows each pop, so the modem never sees a stale head twice
    // Limitation: a software read and a modem pop in one cycle both take the head
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_valid   <= 1'b0;
            tx_data    <= MPRB_RST_FIFO;
            rx_ready   <= 1'b0;
            fifo_full  <= 1'b0;
            fifo_empty <= 1'b1;
        end else begin
            tx_valid   <= f_out_valid && !rd_fifo && !tx_pop;
            tx_data    <= f_out_data;
            rx_ready   <= f_in_ready && !is_sleep;
            fifo_full  <= f_full;
            fifo_empty <= f_empty;
        end
    end

    // ------------------------------------------------------------
    // External page forwarding
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ext_wr    <= 1'b0;
            ext_rd    <= 1'b0;
            ext_addr  <= MPRB_ADDR_FIFO;
            ext_wdata <= MPRB_ZERO;
        end else begin
            ext_wr    <= req.wr && !is_local;
            ext_rd    <= req.rd && !is_local;
            ext_addr  <= req.addr;
            ext_wdata <= req.wdata;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = MPRB_ZERO;
        if (req.rd) begin
            unique case (req.addr)
                MPRB_ADDR_FIFO:     next_rdata = rd_fifo && f_out_valid ? f_out_data : MPRB_ZERO;
                MPRB_ADDR_OPMODE:   next_rdata = {modem_select, shared_page_select, 2'h0,
                                                  band_set_select, device_mode};
                MPRB_ADDR_RSVD_C:   next_rdata = reserved_c;
                MPRB_ADDR_FRF_HIGH: next_rdata = carrier_freq_word[23:16];
                MPRB_ADDR_FRF_MID:  next_rdata = carrier_freq_mid;
                MPRB_ADDR_FRF_LOW:  next_rdata = carrier_freq_low;
                default:            next_rdata = MPRB_ZERO;
            endcase
        end
    end

    // Forwarded pages answer on their own path; here they read as zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata <= MPRB_ZERO;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_modem_sleep_only: assert property (
        !$past(is_sleep) |-> modem_select == $past(modem_select))
        else $error("modem bit changed outside sleep");
    chk_overlay_window: assert property (
        modem_select && shared_page_select && in_shared |-> ##1 fsk_page_sel)
        else $error("shared overlay not applied");
    chk_overlay_confined: assert property (
        modem_select && !in_shared && !is_local |-> ##1 native_page_sel)
        else $error("overlay leaked outside window");
    chk_fsk_page_mode: assert property (
        !modem_select && !is_local |-> ##1 fsk_page_sel && !native_page_sel)
        else $error("native page visible in fsk mode");
    // Status flag lags the flush by two register stages, tx_valid by one
    chk_fifo_sleep_flush: assert property (
        is_sleep |-> ##1 !tx_valid ##1 fifo_empty)
        else $error("fifo not flushed in sleep");
    chk_mode_trigger: assert property (
        req.wr && req.addr == MPRB_ADDR_OPMODE |=>
        mode_trigger && device_mode == $past(req.wdata[MPRB_MODE_MSB:MPRB_MODE_LSB]))
        else $error("mode write did not trigger");
    chk_freq_high: assert property (
        req.wr && req.addr == MPRB_ADDR_FRF_HIGH |=> carrier_freq_word[23:16] == $past(req.wdata))
        else $error("frequency high byte not stored");
    chk_reserved_zero: assert property (
        req.rd && (req.addr == MPRB_ADDR_RSVD_A || req.addr == MPRB_ADDR_RSVD_D) |=> rdata == MPRB_ZERO)
        else $error("reserved location not zero");
    chk_opmode_readback: assert property (
        req.rd && req.addr == MPRB_ADDR_OPMODE |=> rdata[MPRB_BIT_BAND] == band_set_select)
        else $error("band bit readback wrong");

    // ------------------------------------------------------------
    // Stored fields, pulses and stream
    // ------------------------------------------------------------
    chk_reserved_store: assert property (
        req.wr && req.addr == MPRB_ADDR_RSVD_C |=> reserved_c == $past(req.wdata))
        else $error("reserved read-write byte not stored");
    chk_fifo_port_sleep: assert property (
        is_sleep && req.rd && req.addr == MPRB_ADDR_FIFO |=> rdata == MPRB_ZERO)
        else $error("fifo port readable in sleep");
    chk_rx_sleep_block: assert property (
        is_sleep |=> !rx_ready)
        else $error("modem push accepted in sleep");
    chk_tx_word_hold: assert property (
        tx_valid && !tx_ready && !rd_fifo && !is_sleep |=> tx_valid && $stable(tx_data))
        else $error("offered fifo word dropped");
    chk_trigger_pulse: assert property (
        !(req.wr && req.addr == MPRB_ADDR_OPMODE) |=> !mode_trigger)
        else $error("mode trigger without mode write");
    chk_shared_store: assert property (
        req.wr && req.addr == MPRB_ADDR_OPMODE |=> shared_page_select == $past(req.wdata[MPRB_BIT_SHARED]))
        else $error("shared select not stored");
    chk_band_store: assert property (
        req.wr && req.addr == MPRB_ADDR_OPMODE |=> band_set_select == $past(req.wdata[MPRB_BIT_BAND]))
        else $error("band select not stored");
    chk_local_no_forward: assert property (
        (req.wr || req.rd) && is_local |=> !ext_wr && !ext_rd)
        else $error("local register access forwarded");

    cov_modem_switch: cover property (is_sleep ##1 $changed(modem_select));
    cov_rx_push:      cover property (rx_valid && rx_ready);
    cov_overlay_used: cover property (modem_select && shared_page_select && in_shared && req.wr);
    cov_fifo_fill:    cover property (fifo_full);
    cov_fifo_read:    cover property (rd_fifo && f_out_valid);
endmodule : mprb_bank
`default_nettype wire

/* bench/testbench.sv */
// Self-checking testbench for the modem page register bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import mprb_pkg::*;
    logic                   ref_clk     = 1'b0;
    logic                   rst         = 1'b1;
    mprb_pkg::mprb_req_type req         = '0;
    logic                   tx_ready    = 1'b0;
    logic                   rx_valid    = 1'b0;
    logic [7:0]             rx_data     = 8'h00;
    logic [7:0]             ext_rdata   = 8'h00;
    logic [7:0]             rdata;
    logic                   fsk_page_sel;
    logic                   native_page_sel;
    logic                   ext_wr;
    logic                   ext_rd;
    logic [6:0]             ext_addr;
    logic [7:0]             ext_wdata;
    logic                   modem_select;
    logic                   band_set_select;
    logic [2:0]             device_mode;
    logic                   mode_trigger;
    logic [23:0]            carrier_freq_word;
    logic                   tx_valid;
    logic [7:0]             tx_data;
    logic                   rx_ready;
    logic                   fifo_full;
    logic                   fifo_empty;
    int                     n_mismatch  = 0;
    int                     num_checks  = 0;
    logic [7:0]             d;

    mprb_bank #(.FIFO_DEPTH(4)) uut (
        .ref_clk(ref_clk), .rst(rst), .req(req), .rdata(rdata),
        .fsk_page_sel(fsk_page_sel), .native_page_sel(native_page_sel),
        .ext_wr(ext_wr), .ext_rd(ext_rd), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
        .ext_rdata(ext_rdata), .modem_select(modem_select), .band_set_select(band_set_select),
        .device_mode(device_mode), .mode_trigger(mode_trigger), .carrier_freq_word(carrier_freq_word),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_data(rx_data), .fifo_full(fifo_full), .fifo_empty(fifo_empty)
    );

    always #50 ref_clk = ~ref_clk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    // Strobe set after one edge, taken at the next, results sampled mid-cycle
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge ref_clk);
        req <= '0;
        @(negedge ref_clk);
    endtask : wr

    task automatic rd(input logic [6:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge ref_clk);
        req <= '0;
        @(negedge ref_clk);
        v = rdata;
    endtask : rd

    task automatic page(input logic [6:0] a, input logic fwd, input logic fsk);
        wr(a, 8'h5A);
        check(ext_wr, fwd);
        if (fwd) begin
            check({ext_addr, ext_wdata}, {a, 8'h5A});
            check({fsk_page_sel, native_page_sel}, {fsk, !fsk});
        end
    endtask : page

    // Drain with the modem side stalling every other cycle
    task automatic drain(input logic [7:0] e [4], input int n);
        int got;
        got = 0;
        for (int k = 0; k < 40 && got < n; k++) begin
            @(posedge ref_clk);
            tx_ready <= k[0];
            @(negedge ref_clk);
            if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
                check(tx_data, e[got]);
                got++;
            end
        end
        @(posedge ref_clk);
        tx_ready <= 1'b0;
        check(got, n);
        repeat (2) @(negedge ref_clk);
        check({fifo_empty, tx_valid}, 2'b10);
    endtask : drain

    // Valid held until an edge that samples ready high, released right after it
    task automatic push_rx(input logic [7:0] v);
        int k;
        k = 0;
        @(posedge ref_clk);
        rx_valid <= 1'b1;
        rx_data  <= v;
        do begin
            @(posedge ref_clk);
            k++;
        end while (rx_ready !== 1'b1 && k < 20);
        rx_valid <= 1'b0;
        check(rx_ready, 1'b1);
    endtask : push_rx

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd(MPRB_ADDR_OPMODE, d);
        check(d, 8'h09);
        check({modem_select, band_set_select, device_mode}, 5'b0_1_001);
        rd(MPRB_ADDR_FRF_HIGH, d);
        check(d, 8'h6C);
        check(carrier_freq_word, 24'h6C8000);
        check(fifo_empty, 1'b1);
        page(7'h0D, 1'b1, 1'b1);
    endtask : t_reset

    task automatic t_reserved();
        logic [6:0] a;
        for (int i = 2; i < 6; i++) begin
            a = 7'(i);
            wr(a, 8'hFF);
            rd(a, d);
            check(d, (i == 4) ? 8'hFF : 8'h00);
        end
        wr(MPRB_ADDR_FRF_HIGH, 8'hA5); // written in standby
        rd(MPRB_ADDR_FRF_HIGH, d);
        check({d, carrier_freq_word[23:16]}, 16'hA5A5);
    endtask : t_reserved

    task automatic t_modem();
        wr(MPRB_ADDR_OPMODE, 8'h89);
        check({mode_trigger, modem_select, device_mode}, 5'b1_0_001);
        wr(MPRB_ADDR_OPMODE, 8'h00);
        check({band_set_select, device_mode}, 4'h0);
        wr(MPRB_ADDR_OPMODE, 8'h88);
        check(modem_select, 1'b1);
        wr(MPRB_ADDR_OPMODE, 8'h89);
        wr(MPRB_ADDR_OPMODE, 8'h09);
        rd(MPRB_ADDR_OPMODE, d);
        check(d, 8'h89);
    endtask : t_modem

    task automatic t_pages();
        page(7'h0D, 1'b1, 1'b0);
        page(7'h3F, 1'b1, 1'b0);
        wr(MPRB_ADDR_OPMODE, 8'hC9);
        rd(MPRB_ADDR_OPMODE, d);
        check(d, 8'hC9);
        page(7'h0C, 1'b1, 1'b0);
        page(7'h0D, 1'b1, 1'b1);
        page(7'h3F, 1'b1, 1'b1);
        page(7'h40, 1'b1, 1'b0);
        page(MPRB_ADDR_FRF_HIGH, 1'b0, 1'b0);
        check(carrier_freq_word[23:16], 8'h5A);
        rd(7'h20, d);
        check({ext_rd, ext_addr, fsk_page_sel}, {1'b1, 7'h20, 1'b1});
        wr(MPRB_ADDR_OPMODE, 8'h89);
        page(7'h0D, 1'b1, 1'b0);
    endtask : t_pages

    task automatic t_modes();
        for (int m = 0; m < 7; m++) begin
            wr(MPRB_ADDR_OPMODE, 8'h88 | 8'(m));
            check({mode_trigger, device_mode}, {1'b1, 3'(m)});
        end
        wr(MPRB_ADDR_OPMODE, 8'h89);
    endtask : t_modes

    task automatic t_fifo();
        for (int i = 1; i < 6; i++) wr(MPRB_ADDR_FIFO, 8'(i * 17));
        repeat (2) @(negedge ref_clk);
        check({fifo_full, rx_ready}, 2'b10);
        drain('{8'h11, 8'h22, 8'h33, 8'h44}, 4);
        push_rx(8'h3C);
        push_rx(8'h3D);
        drain('{8'h3C, 8'h3D, 8'h00, 8'h00}, 2);
    endtask : t_fifo

    task automatic t_sleep();
        wr(MPRB_ADDR_FIFO, 8'h77);
        wr(MPRB_ADDR_OPMODE, 8'h88);
        repeat (2) @(negedge ref_clk);
        check({fifo_empty, tx_valid, rx_ready}, 3'b100);
        wr(MPRB_ADDR_FIFO, 8'h66);
        rd(MPRB_ADDR_FIFO, d);
        check({d, fifo_empty}, {8'h00, 1'b1});
        wr(MPRB_ADDR_OPMODE, 8'h89);
    endtask : t_sleep

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_reserved();
        t_modem();
        t_pages();
        t_modes();
        t_fifo();
        t_sleep();
        summarize();
    end

    // Whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_mismatch++;
        summarize();
    end
endmodule : testbench
`default_nettype wire
